/* File: pkg/ufx_pkg.sv */
// Shared constants and types for the extended UART channel control block
package ufx_pkg;

	// Register offsets on the 3-bit host address
	localparam logic [2:0] OFS_ADV_SPECIAL = 3'h4;
	localparam logic [2:0] OFS_SAMPLE_CLOCK = 3'h5;
	localparam logic [2:0] OFS_HALFDUPLEX = 3'h6;
	localparam logic [2:0] OFS_FLOW_THRESH = 3'h6;
	localparam logic [2:0] OFS_FIFO_TRIG = 3'h7;
	localparam logic [2:0] OFS_FIFO_SUMMARY = 3'h7;

	// Reset values
	localparam logic [7:0] RST_ADV_SPECIAL = 8'h00;
	localparam logic [7:0] RST_SAMPLE_CLOCK = 8'h00;
	localparam logic [7:0] RST_HALFDUPLEX = 8'h00;
	localparam logic [7:0] RST_FLOW_THRESH = 8'h00;
	localparam logic [7:0] RST_FIFO_TRIG = 8'h00;
	localparam logic [7:0] RST_FIFO_SUMMARY = 8'hFF;

	// Line control value that opens the enhanced bank
	localparam logic [7:0] LINE_CTRL_ENHANCED = 8'hBF;

	// Bit positions
	localparam int LC_DIVLATCH_BIT = 7;
	localparam int MC_RTS_BIT = 1;
	localparam int MC_SUMMARY_EN_BIT = 2;
	localparam int MC_LOOPBACK_BIT = 4;
	localparam int MC_TRIG_BANK_BIT = 6;
	localparam int ASR_HDX_ACCESS_BIT = 7;
	localparam int ASR_TX_DISABLE_BIT = 6;
	localparam int ASR_RX_DISABLE_BIT = 5;
	localparam int ASR_IR_FAST_BIT = 4;
	localparam int ASR_IR_INVERT_BIT = 3;
	localparam int ASR_SAMPLE_EN_BIT = 2;
	localparam int ASR_SUMMARY_BLOCK_BIT = 0;
	localparam int HDX_POLARITY_BIT = 5;
	localparam int HDX_AUTO_DIR_BIT = 4;
	localparam int HDX_NINE_BIT = 0;

	// Writable bits of the half-duplex register; the rest read as zero
	localparam logic [7:0] HDX_WRITE_MASK = 8'h31;

	// FIFO depth in characters
	localparam logic [6:0] FIFO_DEPTH = 7'h40;

	// Reserved channel bits of the summary register read as one
	localparam logic [1:0] SUMMARY_PAD = 2'h3;

	// Reset level of the filtered bus pins: strobes and selects idle high
	localparam logic [13:0] BUS_PIN_IDLE = 14'h3800;

	// Register selected by an access
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_ADV_SPECIAL,
		SEL_SAMPLE_CLOCK,
		SEL_HALFDUPLEX,
		SEL_FLOW_THRESH,
		SEL_FIFO_TRIG,
		SEL_FIFO_SUMMARY
	} ufx_sel_t;

endpackage

/* File: rtl/ufx_sync3.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module ufx_sync3 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic ref_clk, // Device clock
	input wire logic sys_rst, // Asynchronous reset, active high
	input wire logic [W-1:0] din, // Asynchronous pin levels
	output logic [W-1:0] dout // Filtered level
);
	logic [W-1:0] s1_reg; // First stage, read only by the second
	logic [W-1:0] s2_reg; // Second stage
	logic [W-1:0] s3_reg; // Third stage
	logic [W-1:0] out_reg; // Accepted level
	logic [W-1:0] out_next; // Next accepted level

	// A bit changes only once stages two and three agree
	always_comb begin
		out_next = out_reg;
		for (int i = 0; i < W; i++) begin
			if (s2_reg[i] == s3_reg[i]) begin
				out_next[i] = s3_reg[i];
			end
		end
	end

	// Shift chain and accepted level
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
			out_reg <= RST_VAL;
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			out_reg <= out_next;
		end
	end

	assign dout = out_reg;
endmodule // ufx_sync3

/* File: rtl/ufx_level_sel.sv */
// Threshold level picker: programmed field times four, or table level when zero
`timescale 1ns/1ps
module ufx_level_sel
	import ufx_pkg::*;
(
	input wire logic [3:0] field, // Programmed field, units of four characters
	input wire logic [6:0] table_level, // Level chosen by the FIFO tables
	output logic [6:0] level // Level in effect
);
	// Zero field falls back to the table level
	always_comb begin
		if (field == 4'h0) begin
			level = table_level;
		end else begin
			level = {1'b0, field, 2'b00};
		end
	end
endmodule // ufx_level_sel

/* File: rtl/ufx_chan_ext.sv */
// Extended per-channel UART control: access gating, baud prescale, direction and flow control
// Overview of operation
// - Special bit 3 inverts infrared receive input
// - Special bit 2 opens sample clock register
// - Special bit 0 blocks FIFO summary access
// - Sample clock needs LC7, not BF, bit2
// - Sample count upper nibble, prescale lower nibble
// - Half-duplex bit 5 inverts direction output
// - Half-duplex bit 4 lets transmitter drive RTS
// - Half-duplex bit 0 selects nine-bit mode
// - Special bit 7 opens half-duplex register
// - Thresholds need LC7 clear, modem bit 6
// - Count at or below resume restarts flow
// - Count at or above halt stops flow
// - RX count reaching trigger raises interrupt
// - TX free space reaching trigger raises interrupt
// - Summary readable under modem, special, select gating
// - Summary holds RX nibble high, TX low
// - RX DMA ready within one baud clock
// - TX DMA ready drops within eight baud clocks
// - Interrupt within one baud clock of stop
`timescale 1ns/1ps
module ufx_chan_ext
	import ufx_pkg::*;
(
	input wire logic ref_clk, // Device clock, 40 MHz
	input wire logic sys_rst, // Asynchronous reset, active high
	input wire logic [2:0] bus_addr, // Register address pins
	input wire logic [7:0] bus_data_in, // Data bus pins, inward
	output logic [7:0] bus_data_out, // Data bus, outward
	output logic bus_data_oe, // Data bus drive enable
	input wire logic chip_sel_n, // This channel's select pin
	input wire logic [1:0] channel_selects_n, // All channel select pins
	input wire logic rd_strobe_n, // Read strobe pin
	input wire logic wr_strobe_n, // Write strobe pin
	input wire logic [7:0] line_control, // Line control register value
	input wire logic [7:0] modem_control, // Modem control register value
	input wire logic enhanced_en, // Enhanced-function enable bit
	input wire logic [6:0] rx_fifo_count, // Characters in RX FIFO
	input wire logic [6:0] tx_fifo_count, // Characters in TX FIFO
	input wire logic [6:0] table_rx_trigger, // Table RX trigger level
	input wire logic [6:0] table_tx_trigger, // Table TX trigger level
	input wire logic [6:0] table_halt, // Table halt level
	input wire logic [6:0] table_resume, // Table resume level
	input wire logic auto_rts_en, // Automatic RTS flow enabled
	input wire logic auto_xonxoff_en, // Automatic software flow enabled
	input wire logic tx_active, // Transmitter is sending
	input wire logic rx_char_done, // Pulse at end of received stop bit
	input wire logic [1:0] chan_rx_rdy_n, // RX ready of each channel, active low
	input wire logic [1:0] chan_tx_rdy_n, // TX ready of each channel, active low
	input wire logic rx_line_in, // Infrared receive pin
	output logic rx_decoder_in, // Receive level to the decoder
	output logic rts_n, // RTS pin level
	output logic xon_request, // Pulse: send XON
	output logic xoff_request, // Pulse: send XOFF
	output logic rx_data_ready_int, // Receive data ready interrupt
	output logic tx_ready_int, // Transmit ready interrupt
	output logic rx_dma_ready_n, // Receive DMA ready, active low
	output logic tx_dma_ready_n, // Transmit DMA ready, active low
	output logic baud_sample_tick, // Sample clock pulse
	output logic baud_bit_tick, // Bit period pulse
	output logic sample_clock_active, // Prescaler path drives baud
	output logic nine_bit_mode, // Nine-bit address mode
	output logic tx_disable, // Transmitter disabled
	output logic rx_disable, // Receiver disabled
	output logic ir_fast_mode // Infrared fast mode
);
	// Filtered pins
	logic [13:0] pin_raw; // Bus pins bundled for sync
	logic [13:0] pin_sync; // Filtered bus pins
	logic rx_line_sync; // Filtered infrared input
	logic [2:0] p_addr; // Filtered address
	logic [7:0] p_data; // Filtered write data
	logic p_cs_n; // Filtered channel select
	logic p_rd_n; // Filtered read strobe
	logic p_wr_n; // Filtered write strobe

	// Register state
	logic [7:0] asr_reg, asr_next; // Advanced special control
	logic [7:0] snr_reg, snr_next; // Sample clock config
	logic [7:0] hdx_reg, hdx_next; // Half-duplex direction control
	logic [7:0] tcr_reg, tcr_next; // Flow halt/resume thresholds
	logic [7:0] tlr_reg, tlr_next; // FIFO interrupt triggers
	logic [7:0] fsum_reg, fsum_next; // FIFO ready summary
	logic [2:0] wa_reg, wa_next; // Latched write address
	logic [7:0] wd_reg, wd_next; // Latched write data
	logic wsel_reg, wsel_next; // Latched write select
	logic wr_prev_reg, wr_prev_next; // Previous write strobe
	logic [7:0] rdata_reg, rdata_next; // Read data
	logic roe_reg, roe_next; // Read drive enable

	// Flow, interrupt and DMA state
	logic halt_reg, halt_next; // Receive flow halted
	logic xon_reg, xon_next; // XON request pulse
	logic xoff_reg, xoff_next; // XOFF request pulse
	logic rxi_reg, rxi_next; // RX interrupt level
	logic txi_reg, txi_next; // TX interrupt level
	logic rxd_n_reg, rxd_n_next; // RX DMA ready
	logic txd_n_reg, txd_n_next; // TX DMA ready
	logic rts_n_reg, rts_n_next; // RTS pin
	logic rxin_reg, rxin_next; // Decoder input

	// Baud state
	logic [3:0] pre_reg, pre_next; // Prescale counter
	logic [3:0] ovs_reg, ovs_next; // Oversample counter
	logic stk_reg, stk_next; // Sample tick
	logic btk_reg, btk_next; // Bit tick

	// Thresholds
	logic [6:0] lvl [4]; // Resume, halt, RX trigger, TX trigger
	logic [15:0] lvl_fields; // Fields feeding the pickers
	logic [27:0] lvl_tables; // Table levels feeding the pickers
	logic [6:0] tx_free; // Free space in TX FIFO
	logic write_hit; // Write completes this cycle
	ufx_sel_t wr_sel; // Register a write lands in
	ufx_sel_t rd_sel; // Register a read comes from

	// Register decode, shared by reads and writes
	function automatic ufx_sel_t decode(input logic [2:0] a, input logic [7:0] lc, input logic [7:0] mc,
			input logic [7:0] advanced_special_control, input logic enh, input logic any_cs);
		logic bank_hi;
		bank_hi = lc[LC_DIVLATCH_BIT] && (lc != LINE_CTRL_ENHANCED);
		decode = SEL_NONE;
		if (bank_hi) begin
			if (a == OFS_ADV_SPECIAL && enh) begin
				decode = SEL_ADV_SPECIAL;
			end else if (a == OFS_SAMPLE_CLOCK && advanced_special_control[ASR_SAMPLE_EN_BIT]) begin
				decode = SEL_SAMPLE_CLOCK;
			end else if (a == OFS_HALFDUPLEX && advanced_special_control[ASR_HDX_ACCESS_BIT]) begin
				decode = SEL_HALFDUPLEX;
			end
		end else if (!lc[LC_DIVLATCH_BIT]) begin
			if (mc[MC_TRIG_BANK_BIT] && a == OFS_FLOW_THRESH) begin
				decode = SEL_FLOW_THRESH;
			end else if (mc[MC_TRIG_BANK_BIT] && a == OFS_FIFO_TRIG) begin
				decode = SEL_FIFO_TRIG;
			end else if (a == OFS_FIFO_SUMMARY && !mc[MC_LOOPBACK_BIT] && mc[MC_SUMMARY_EN_BIT]
					&& !advanced_special_control[ASR_SUMMARY_BLOCK_BIT] && any_cs) begin
				decode = SEL_FIFO_SUMMARY;
			end
		end
	endfunction

	assign pin_raw = {wr_strobe_n, rd_strobe_n, chip_sel_n, bus_data_in, bus_addr};
	assign {p_wr_n, p_rd_n, p_cs_n, p_data, p_addr} = pin_sync;

	// Bus pin synchroniser
	ufx_sync3 #(.W(14), .RST_VAL(BUS_PIN_IDLE)) u_bus_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.din(pin_raw),
		.dout(pin_sync)
	);

	// Infrared receive pin synchroniser
	ufx_sync3 #(.W(1), .RST_VAL(1'b1)) u_rx_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.din(rx_line_in),
		.dout(rx_line_sync)
	);

	assign lvl_fields = {tlr_reg[3:0], tlr_reg[7:4], tcr_reg[3:0], tcr_reg[7:4]};
	assign lvl_tables = {table_tx_trigger, table_rx_trigger, table_halt, table_resume};

	// Four threshold pickers
	generate
		for (genvar g = 0; g < 4; g++) begin : g_lvl
			ufx_level_sel u_lvl (
				.field(lvl_fields[g*4 +: 4]),
				.table_level(lvl_tables[g*7 +: 7]),
				.level(lvl[g])
			);
		end
	endgenerate

	assign tx_free = FIFO_DEPTH - tx_fifo_count;
	assign write_hit = p_wr_n && !wr_prev_reg && wsel_reg;
	assign wr_sel = decode(wa_reg, line_control, modem_control, asr_reg, enhanced_en, 1'b0);
	assign rd_sel = decode(p_addr, line_control, modem_control, asr_reg, enhanced_en, !(&channel_selects_n));

	// Host access: latch during the write strobe, commit on its release
	always_comb begin
		asr_next = asr_reg;
		snr_next = snr_reg;
		hdx_next = hdx_reg;
		tcr_next = tcr_reg;
		tlr_next = tlr_reg;
		wa_next = wa_reg;
		wd_next = wd_reg;
		wsel_next = wsel_reg;
		wr_prev_next = p_wr_n;
		rdata_next = rdata_reg;
		roe_next = !p_rd_n && !p_cs_n;
		if (!p_wr_n) begin
			// Strobe low: track address, data, select
			wa_next = p_addr;
			wd_next = p_data;
			wsel_next = !p_cs_n;
		end
		if (write_hit) begin
			case (wr_sel)
				SEL_ADV_SPECIAL: asr_next = wd_reg;
				SEL_SAMPLE_CLOCK: snr_next = wd_reg;
				SEL_HALFDUPLEX: hdx_next = wd_reg & HDX_WRITE_MASK;
				SEL_FLOW_THRESH: tcr_next = wd_reg;
				SEL_FIFO_TRIG: tlr_next = wd_reg;
				default: asr_next = asr_reg;
			endcase
		end
		// Read data follows the selected register; the summary needs no own select
		case (rd_sel)
			SEL_ADV_SPECIAL: rdata_next = asr_reg;
			SEL_SAMPLE_CLOCK: rdata_next = snr_reg;
			SEL_HALFDUPLEX: rdata_next = hdx_reg;
			SEL_FLOW_THRESH: rdata_next = tcr_reg;
			SEL_FIFO_TRIG: rdata_next = tlr_reg;
			SEL_FIFO_SUMMARY: begin
				rdata_next = fsum_reg;
				roe_next = !p_rd_n;
			end
			default: rdata_next = 8'h00;
		endcase
	end

	// Summary of channel FIFO readiness
	always_comb begin
		fsum_next = {SUMMARY_PAD, chan_rx_rdy_n, SUMMARY_PAD, chan_tx_rdy_n};
	end

	// Baud prescale: (prescale + 1)-step prescaler, then (16 - sample count) samples per bit
	always_comb begin
		pre_next = pre_reg;
		ovs_next = ovs_reg;
		stk_next = 1'b0;
		btk_next = 1'b0;
		if (!asr_reg[ASR_SAMPLE_EN_BIT]) begin
			pre_next = 4'h0;
			ovs_next = 4'h0;
		end else if (pre_reg >= snr_reg[3:0]) begin
			pre_next = 4'h0;
			stk_next = 1'b1;
			if (ovs_reg >= 4'(4'hF - snr_reg[7:4])) begin
				ovs_next = 4'h0;
				btk_next = 1'b1;
			end else begin
				ovs_next = ovs_reg + 4'h1;
			end
		end else begin
			pre_next = pre_reg + 4'h1;
		end
	end

	// Flow control, interrupts, DMA and direction
	always_comb begin
		halt_next = halt_reg;
		xon_next = 1'b0;
		xoff_next = 1'b0;
		if (rx_fifo_count >= lvl[1]) begin
			halt_next = 1'b1;
		end else if (rx_fifo_count <= lvl[0]) begin
			halt_next = 1'b0;
		end
		if (auto_xonxoff_en && halt_next && !halt_reg) begin
			xoff_next = 1'b1;
		end
		if (auto_xonxoff_en && !halt_next && halt_reg) begin
			xon_next = 1'b1;
		end
		// Level interrupts settle one cycle after the count moves
		rxi_next = (rx_fifo_count >= lvl[2]) && (rx_fifo_count != 7'h00);
		txi_next = tx_free >= lvl[3];
		// RX DMA ready: set at stop bit end, dropped when FIFO drains; set wins
		rxd_n_next = rxd_n_reg;
		if (rx_char_done && rx_fifo_count >= lvl[2]) begin
			rxd_n_next = 1'b0;
		end else if (rx_fifo_count == 7'h00) begin
			rxd_n_next = 1'b1;
		end
		txd_n_next = !(tx_free >= lvl[3]);
		// RTS pin: direction control first, then automatic flow, then modem bit
		if (hdx_reg[HDX_AUTO_DIR_BIT]) begin
			rts_n_next = tx_active ^ hdx_reg[HDX_POLARITY_BIT];
		end else if (auto_rts_en) begin
			rts_n_next = halt_next;
		end else begin
			rts_n_next = !modem_control[MC_RTS_BIT];
		end
		rxin_next = rx_line_sync ^ asr_reg[ASR_IR_INVERT_BIT];
	end

	// Register all state
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			asr_reg <= RST_ADV_SPECIAL;
			snr_reg <= RST_SAMPLE_CLOCK;
			hdx_reg <= RST_HALFDUPLEX;
			tcr_reg <= RST_FLOW_THRESH;
			tlr_reg <= RST_FIFO_TRIG;
			fsum_reg <= RST_FIFO_SUMMARY;
			wa_reg <= 3'h0;
			wd_reg <= 8'h00;
			wsel_reg <= 1'b0;
			wr_prev_reg <= 1'b1;
			rdata_reg <= 8'h00;
			roe_reg <= 1'b0;
			halt_reg <= 1'b0;
			xon_reg <= 1'b0;
			xoff_reg <= 1'b0;
			rxi_reg <= 1'b0;
			txi_reg <= 1'b0;
			rxd_n_reg <= 1'b1;
			txd_n_reg <= 1'b1;
			rts_n_reg <= 1'b1;
			rxin_reg <= 1'b1;
			pre_reg <= 4'h0;
			ovs_reg <= 4'h0;
			stk_reg <= 1'b0;
			btk_reg <= 1'b0;
		end else begin
			asr_reg <= asr_next;
			snr_reg <= snr_next;
			hdx_reg <= hdx_next;
			tcr_reg <= tcr_next;
			tlr_reg <= tlr_next;
			fsum_reg <= fsum_next;
			wa_reg <= wa_next;
			wd_reg <= wd_next;
			wsel_reg <= wsel_next;
			wr_prev_reg <= wr_prev_next;
			rdata_reg <= rdata_next;
			roe_reg <= roe_next;
			halt_reg <= halt_next;
			xon_reg <= xon_next;
			xoff_reg <= xoff_next;
			rxi_reg <= rxi_next;
			txi_reg <= txi_next;
			rxd_n_reg <= rxd_n_next;
			txd_n_reg <= txd_n_next;
			rts_n_reg <= rts_n_next;
			rxin_reg <= rxin_next;
			pre_reg <= pre_next;
			ovs_reg <= ovs_next;
			stk_reg <= stk_next;
			btk_reg <= btk_next;
		end
	end

	// Outputs
	assign bus_data_out = rdata_reg;
	assign bus_data_oe = roe_reg;
	assign rx_decoder_in = rxin_reg;
	assign rts_n = rts_n_reg;
	assign xon_request = xon_reg;
	assign xoff_request = xoff_reg;
	assign rx_data_ready_int = rxi_reg;
	assign tx_ready_int = txi_reg;
	assign rx_dma_ready_n = rxd_n_reg;
	assign tx_dma_ready_n = txd_n_reg;
	assign baud_sample_tick = stk_reg;
	assign baud_bit_tick = btk_reg;
	assign sample_clock_active = asr_reg[ASR_SAMPLE_EN_BIT];
	assign nine_bit_mode = hdx_reg[HDX_NINE_BIT];
	assign tx_disable = asr_reg[ASR_TX_DISABLE_BIT];
	assign rx_disable = asr_reg[ASR_RX_DISABLE_BIT];
	assign ir_fast_mode = asr_reg[ASR_IR_FAST_BIT];
endmodule // ufx_chan_ext

/* File: bench/ufx_chan_ext_props.sv */
// Port-level checker for the extended UART channel control block
`timescale 1ns/1ps
module ufx_chan_ext_props (
	input wire logic ref_clk, // Device clock
	input wire logic sys_rst, // Asynchronous reset
	input wire logic rd_strobe_n, // Read strobe
	input wire logic wr_strobe_n, // Write strobe
	input wire logic chip_sel_n, // Channel select
	input wire logic [6:0] rx_fifo_count, // RX fill level
	input wire logic rx_char_done, // End of stop bit
	input wire logic rx_line_in, // Infrared pin
	input wire logic rx_decoder_in, // Decoder level
	input wire logic bus_data_oe, // Data drive enable
	input wire logic xon_request, // XON pulse
	input wire logic xoff_request, // XOFF pulse
	input wire logic rx_data_ready_int, // RX interrupt
	input wire logic tx_ready_int, // TX interrupt
	input wire logic rx_dma_ready_n, // RX DMA ready
	input wire logic tx_dma_ready_n, // TX DMA ready
	input wire logic baud_sample_tick, // Sample pulse
	input wire logic sample_clock_active, // Prescaler on
	input wire logic nine_bit_mode, // Nine-bit mode
	input wire logic ir_fast_mode // Infrared fast mode
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic [3:0] wr_age_reg; // Cycles since the write strobe was last low
	logic [3:0] wr_age_next; // Next age
	// Saturating age of the last write, so settings may only move just after one
	always_comb begin
		wr_age_next = wr_age_reg;
		if (!wr_strobe_n) begin
			wr_age_next = 4'h0;
		end else if (wr_age_reg != 4'hF) begin
			wr_age_next = wr_age_reg + 4'h1;
		end
	end
	// Age register
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_age_reg <= 4'h0;
		end else begin
			wr_age_reg <= wr_age_next;
		end
	end
	sequence rd_held;
		(!rd_strobe_n && !chip_sel_n) [*8];
	endsequence
	sequence line_quiet;
		$stable(rx_line_in) [*6] ##0 (wr_age_reg == 4'hF);
	endsequence
	chk_read_drives_bus: assert property (rd_held |-> bus_data_oe) else $error("read not driven");
	chk_idle_bus_free: assert property (rd_strobe_n [*8] |-> !bus_data_oe) else $error("bus driven idle");
	chk_ir_level_steady: assert property (line_quiet |-> $stable(rx_decoder_in)) else $error("decoder moved");
	chk_setting_after_write: assert property (($changed(nine_bit_mode) || $changed(ir_fast_mode)
		|| $changed(sample_clock_active)) |-> wr_age_reg <= 4'h8) else $error("setting moved");
	chk_rx_int_nonempty: assert property (rx_data_ready_int |-> $past(rx_fifo_count) != 7'h00)
		else $error("rx int on empty");
	chk_rx_dma_set: assert property ($fell(rx_dma_ready_n) |-> $past(rx_char_done)) else $error("dma set");
	chk_rx_dma_clear: assert property ($rose(rx_dma_ready_n) |-> $past(rx_fifo_count) == 7'h00)
		else $error("dma clear");
	chk_tx_dma_pairs: assert property (tx_dma_ready_n != tx_ready_int) else $error("tx dma vs int");
	chk_flow_pulse_excl: assert property (xoff_request |-> !xon_request) else $error("xon with xoff");
	chk_baud_idle: assert property (!sample_clock_active [*2] |-> !baud_sample_tick) else $error("tick");
endmodule // ufx_chan_ext_props

/* File: bench/ufx_host_model.sv */
// Host processor model driving the channel's parallel register bus
`timescale 1ns/1ps
module ufx_host_model (
	input wire logic ref_clk, // Device clock
	input wire logic [7:0] bus_data_out, // Read data from the channel
	input wire logic bus_data_oe, // Channel drives data
	output logic [2:0] bus_addr, // Address pins
	output logic [7:0] host_data, // Data the host puts on the bus
	output logic chip_sel_n, // Select pin
	output logic rd_strobe_n, // Read strobe
	output logic wr_strobe_n // Write strobe
);
	// Idle bus at time zero
	initial begin
		bus_addr = 3'h0;
		host_data = 8'h00;
		chip_sel_n = 1'b1;
		rd_strobe_n = 1'b1;
		wr_strobe_n = 1'b1;
	end
	// Strobe eight cycles low and eight high, well above the filter's three
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		bus_addr = a;
		host_data = d;
		chip_sel_n = 1'b0;
		wr_strobe_n = 1'b0;
		repeat (8) @(negedge ref_clk);
		wr_strobe_n = 1'b1;
		repeat (8) @(negedge ref_clk);
		chip_sel_n = 1'b1;
		host_data = ~d; // Released bus must not keep showing the byte
	endtask
	// Read cycle; data taken at a rising edge while the strobe is still low
	task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic e);
		@(negedge ref_clk);
		bus_addr = a;
		chip_sel_n = 1'b0;
		rd_strobe_n = 1'b0;
		repeat (8) @(negedge ref_clk);
		@(posedge ref_clk);
		d = bus_data_out;
		e = bus_data_oe;
		@(negedge ref_clk);
		rd_strobe_n = 1'b1;
		repeat (8) @(negedge ref_clk);
		chip_sel_n = 1'b1;
	endtask
endmodule // ufx_host_model

/* File: bench/test_uart_flow_halfduplex_direction_control_extensions.sv */
// Self-checking bench for the extended UART channel control block
`timescale 1ns/1ps
module test_uart_flow_halfduplex_direction_control_extensions;
	logic ref_clk, sys_rst, chip_sel_n, rd_strobe_n, wr_strobe_n, enhanced_en, auto_rts_en, auto_xonxoff_en;
	logic tx_active, rx_char_done, rx_line_in, rx_decoder_in, rts_n, xon_request, xoff_request, bus_data_oe;
	logic rx_data_ready_int, tx_ready_int, rx_dma_ready_n, tx_dma_ready_n, baud_sample_tick, baud_bit_tick;
	logic sample_clock_active, nine_bit_mode, tx_disable, rx_disable, ir_fast_mode;
	logic [2:0] bus_addr;
	logic [7:0] bus_data_in, bus_data_out, host_data, line_control, modem_control;
	logic [6:0] rx_fifo_count, tx_fifo_count, table_rx_trigger, table_tx_trigger, table_halt, table_resume;
	logic [1:0] channel_selects_n, chan_rx_rdy_n, chan_tx_rdy_n;
	int err_count, n_compared, ns, nb;
	// Rows: line control, modem control, address, write flag, data or expected read
	logic [31:0] rows [17] = '{32'h8000_4185, 32'h8000_4085,
		32'h8000_51C1, 32'h8000_50C1,
		32'h8000_61FF, 32'h8000_6031, 32'hBF00_5000, 32'h0004_7000,
		32'h8000_4180, 32'h8000_5000, 32'h0004_70DE, 32'h0014_7000,
		32'h0040_6128, 32'h0040_6028, 32'h0040_7141, 32'h0040_7041, 32'h0000_6000};
	assign bus_data_in = bus_data_oe ? bus_data_out : host_data;
	assign channel_selects_n = {1'b1, chip_sel_n};
	ufx_host_model host (.ref_clk, .bus_data_out, .bus_data_oe, .bus_addr, .host_data, .chip_sel_n,
		.rd_strobe_n, .wr_strobe_n);
	ufx_chan_ext dut (.ref_clk, .sys_rst, .bus_addr, .bus_data_in, .bus_data_out, .bus_data_oe, .chip_sel_n,
		.channel_selects_n, .rd_strobe_n, .wr_strobe_n, .line_control, .modem_control, .enhanced_en,
		.rx_fifo_count, .tx_fifo_count, .table_rx_trigger, .table_tx_trigger, .table_halt, .table_resume,
		.auto_rts_en, .auto_xonxoff_en, .tx_active, .rx_char_done, .chan_rx_rdy_n, .chan_tx_rdy_n, .rx_line_in,
		.rx_decoder_in, .rts_n, .xon_request, .xoff_request, .rx_data_ready_int, .tx_ready_int, .rx_dma_ready_n,
		.tx_dma_ready_n, .baud_sample_tick, .baud_bit_tick, .sample_clock_active, .nine_bit_mode, .tx_disable,
		.rx_disable, .ir_fast_mode);
	// Clock at 40 MHz
	always #12.5 ref_clk = ~ref_clk;
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic bitc(input logic got, input logic exp, input string what);
		cmp({7'h00, got}, {7'h00, exp}, what);
	endtask
	task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string what);
		logic [7:0] d;
		logic e;
		host.rd(a, d, e);
		cmp(d, exp, what);
	endtask
	// Move the RX count and check RTS and the flow pulses one edge later
	task automatic flow(input logic [6:0] c, input logic r, input logic xn, input logic xf);
		rx_fifo_count = c;
		@(negedge ref_clk);
		bitc(rts_n, r, "rts");
		bitc(xon_request, xn, "xon");
		bitc(xoff_request, xf, "xoff");
		@(negedge ref_clk);
	endtask
	// Finish a character with given fill levels and check interrupts and DMA
	task automatic evt(input logic [6:0] rc, input logic [6:0] tc, input logic ri, input logic ti);
		rx_fifo_count = rc;
		tx_fifo_count = tc;
		rx_char_done = 1'b1;
		@(negedge ref_clk);
		rx_char_done = 1'b0;
		bitc(rx_data_ready_int, ri, "rx int");
		bitc(rx_dma_ready_n, !ri, "rx dma");
		bitc(tx_ready_int, ti, "tx int");
		bitc(tx_dma_ready_n, !ti, "tx dma");
		@(negedge ref_clk);
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Watchdog well beyond the few hundred cycles of the sequence
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		end_of_test();
	end
	// Main sequence
	initial begin
		ref_clk = 1'b0;
		sys_rst = 1'b1;
		{line_control, modem_control, enhanced_en, auto_rts_en, auto_xonxoff_en} = {16'h0000, 3'h4};
		{tx_active, rx_char_done, rx_line_in, rx_fifo_count, tx_fifo_count} = {3'h1, 14'h0000};
		{table_rx_trigger, table_tx_trigger, table_halt, table_resume} = {7'h20, 7'h20, 7'h38, 7'h08};
		{chan_rx_rdy_n, chan_tx_rdy_n} = 4'h6;
		repeat (12) @(negedge ref_clk);
		sys_rst = 1'b0;
		foreach (rows[i]) begin
			{line_control, modem_control} = rows[i][31:16];
			if (rows[i][8]) host.wr(rows[i][14:12], rows[i][7:0]);
			else rdc(rows[i][14:12], rows[i][7:0], "register");
		end
		$display("register rows done");
		line_control = 8'h80;
		host.wr(3'h4, 8'h88);
		repeat (8) @(negedge ref_clk);
		bitc(rx_decoder_in, 1'b0, "ir inverted");
		rx_line_in = 1'b0;
		repeat (8) @(negedge ref_clk);
		bitc(rx_decoder_in, 1'b1, "ir inverted low");
		tx_active = 1'b1;
		host.wr(3'h6, 8'h10);
		repeat (3) @(negedge ref_clk);
		bitc(rts_n, 1'b1, "dir transmit");
		tx_active = 1'b0;
		repeat (3) @(negedge ref_clk);
		bitc(rts_n, 1'b0, "dir receive");
		host.wr(3'h6, 8'h31);
		bitc(nine_bit_mode, 1'b1, "nine bit");
		bitc(rts_n, 1'b1, "dir inverted");
		host.wr(3'h6, 8'h00);
		repeat (3) @(negedge ref_clk);
		bitc(rts_n, 1'b1, "rts released");
		$display("direction done");
		{auto_rts_en, auto_xonxoff_en} = 2'h3;
		flow(7'h1F, 1'b0, 1'b0, 1'b0);
		flow(7'h20, 1'b1, 1'b0, 1'b1);
		flow(7'h09, 1'b1, 1'b0, 1'b0);
		flow(7'h08, 1'b0, 1'b1, 1'b0);
		flow(7'h00, 1'b0, 1'b0, 1'b0);
		{auto_rts_en, auto_xonxoff_en} = 2'h0;
		evt(7'h0F, 7'h00, 1'b0, 1'b1);
		evt(7'h10, 7'h3C, 1'b1, 1'b1);
		evt(7'h10, 7'h3D, 1'b1, 1'b0);
		evt(7'h00, 7'h00, 1'b0, 1'b1);
		$display("flow and interrupts done");
		line_control = 8'h80;
		host.wr(3'h4, 8'h84);
		bitc(sample_clock_active, 1'b1, "prescaler on");
		{ns, nb} = 0;
		repeat (80) begin
			@(negedge ref_clk);
			ns += int'(baud_sample_tick);
			nb += int'(baud_bit_tick);
		end
		cmp(8'(ns), 8'h28, "sample ticks");
		cmp(8'(nb), 8'h0A, "bit ticks");
		host.wr(3'h4, 8'h70);
		bitc(tx_disable, 1'b1, "tx off");
		bitc(rx_disable, 1'b1, "rx off");
		bitc(ir_fast_mode, 1'b1, "ir fast");
		bitc(sample_clock_active, 1'b0, "prescaler off");
		sys_rst = 1'b1;
		repeat (2) @(negedge ref_clk);
		sys_rst = 1'b0;
		bitc(rts_n, 1'b1, "reset rts");
		bitc(bus_data_oe, 1'b0, "reset oe");
		rdc(3'h4, 8'h00, "reset special");
		{line_control, modem_control} = 16'h0040;
		rdc(3'h6, 8'h00, "reset thresholds");
		$display("reset done");
		end_of_test();
	end
endmodule // test_uart_flow_halfduplex_direction_control_extensions
bind ufx_chan_ext ufx_chan_ext_props chk (.ref_clk, .sys_rst, .rd_strobe_n, .wr_strobe_n, .chip_sel_n,
	.rx_fifo_count, .rx_char_done, .rx_line_in, .rx_decoder_in, .bus_data_oe, .xon_request, .xoff_request,
	.rx_data_ready_int, .tx_ready_int, .rx_dma_ready_n, .tx_dma_ready_n, .baud_sample_tick,
	.sample_clock_active, .nine_bit_mode, .ir_fast_mode);
